// ### hdl/wfi_pkg.sv
// constants and carrier types for the wait-for-interrupt clock-stop block
package wfi_pkg;

    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CP_CMD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] WAKE_CAUSE_OFS = 8'h0c;
    localparam logic [7:0] ENTRY_COUNT_OFS = 8'h10;
    localparam logic [7:0] IDLE_CYCLES_OFS = 8'h14;
    localparam logic [7:0] ID_OFS = 8'h18;
    localparam int ADDR_DEC_W = 8;

    // control register fields
    localparam int CTRL_WFI_ENABLE_BIT = 0;
    localparam int CTRL_HALT_REQ_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // coprocessor command word layout
    localparam int CMD_CRM_LSB = 0;
    localparam int CMD_CRN_LSB = 4;
    localparam int CMD_OP2_LSB = 8;
    localparam int CMD_OP1_LSB = 11;

    // the wait-for-interrupt operation: register c7, secondary c0, opcode 4
    localparam logic [3:0] WFI_CRN = 4'h7;
    localparam logic [3:0] WFI_CRM = 4'h0;
    localparam logic [2:0] WFI_OP2 = 3'h4;
    localparam logic [2:0] WFI_OP1 = 3'h0;

    // status register fields
    localparam int STATUS_FLAG_BIT = 0;
    localparam int STATUS_STATE_LSB = 1;
    localparam int STATUS_GRANT_BIT = 3;
    localparam int STATUS_QUIET_BIT = 4;

    // wake cause register width
    localparam int CAUSE_W = 4;

    // clock cycles counted after idle is seen at both bus edges, before the memory system counts as quiet
    localparam logic [1:0] QUIET_SETTLE = 2'h2;

    // arbitrary identification value
    localparam logic [31:0] BLOCK_ID = 32'h0000_5a01;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_DRAIN,
        ST_STANDBY,
        ST_WAKE
    } wfi_state_t;

    typedef struct packed {
        logic [2:0] op1;
        logic [2:0] op2;
        logic [3:0] crn;
        logic [3:0] crm;
    } cp_cmd_t;

    typedef struct packed {
        logic halt_bit;
        logic ext_debug;
        logic fast_int;
        logic normal_int;
    } wake_cause_t;

    typedef struct packed {
        logic wb_empty;
        logic mem_idle;
        logic tcm_idle;
        logic cop_idle;
    } activity_t;

endpackage

// ### hdl/wfi_quiet_monitor.sv
// judges when write buffers and memory interfaces have gone quiet
`timescale 1ns/1ns
`default_nettype none
module wfi_quiet_monitor
    import wfi_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic arm_i,
    input wire activity_t act_i,
    input wire logic dbus_en_i,
    input wire logic ibus_en_i,
    output logic quiet_o
);

    logic all_idle;
    logic dseen_r;
    logic iseen_r;
    logic [1:0] settle_r;

    // buffers must be empty as well as the interfaces idle
    assign all_idle = act_i.wb_empty & act_i.mem_idle & act_i.tcm_idle & act_i.cop_idle;

    // idle must be seen at a bus clock edge, since a slow bus finishes only there
    always_ff @(posedge clk_i) begin
        if (srst_i || !arm_i || !all_idle) begin
            dseen_r <= 1'b0;
            iseen_r <= 1'b0;
        end else begin
            if (dbus_en_i) begin
                dseen_r <= 1'b1;
            end
            if (ibus_en_i) begin
                iseen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !arm_i || !all_idle) begin
            settle_r <= 2'h0;
        end else if (dseen_r && iseen_r && settle_r != QUIET_SETTLE) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            quiet_o <= 1'b0;
        end else begin
            quiet_o <= arm_i & all_idle & (settle_r == QUIET_SETTLE);
        end
    end

endmodule
`default_nettype wire

// ### hdl/wfi_clock_stop.sv
// wait-for-interrupt controller: entry, drain, standby flag and wake-up
`timescale 1ns/1ns
`default_nettype none
module wfi_clock_stop
    import wfi_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    // AHB-Lite register slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // wake sources and the JTAG clock enable, synchronous to CLOCK_I
    input wire logic NORMAL_INTERRUPT_N_I,
    input wire logic FAST_INTERRUPT_N_I,
    input wire logic EXT_DEBUG_REQUEST_I,
    input wire logic JTAG_CLOCK_ENABLE_I,
    // memory system activity
    input wire logic WRITE_BUFFERS_EMPTY_I,
    input wire logic MEM_IDLE_I,
    input wire logic TCM_IDLE_I,
    input wire logic COPROC_IDLE_I,
    input wire logic DATA_BUS_CLOCK_ENABLE_I,
    input wire logic INSTR_BUS_CLOCK_ENABLE_I,
    // power and clock control
    output logic LOW_POWER_IDLE_FLAG_O,
    output logic ACCESS_GRANT_O,
    output logic CORE_CLOCK_ENABLE_O,
    output logic DEBUG_CLOCK_ENABLE_O
);

    wfi_state_t state_r;
    wfi_state_t state_nxt;

    logic [1:0] ctrl_r;
    wake_cause_t cause_r;
    wake_cause_t wake_now;
    logic [31:0] entry_count_r;
    logic [31:0] idle_cycles_r;
    logic flag_r;
    logic grant_r;
    logic core_en_r;
    logic quiet;
    logic idle_now;
    logic wake_any;
    logic wfi_cmd;
    activity_t act;
    cp_cmd_t cmd;

    // AHB address-phase capture
    logic wr_pend_r;
    logic [ADDR_DEC_W-1:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic addr_phase;
    logic [ADDR_DEC_W-1:0] dec_addr;
    logic [31:0] read_mux;
    logic cause_clr;
    logic [CAUSE_W-1:0] cause_clr_mask;

    // bus slave: zero wait states, always OKAY
    // unmapped offsets read zero and drop their writes

    assign addr_phase = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NONSEQ || HTRANS_I == HTRANS_SEQ);
    assign dec_addr = HADDR_I[ADDR_DEC_W-1:0];
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_r;

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end else if (HREADY_I) begin
            wr_pend_r <= addr_phase & HWRITE_I;
            wr_addr_r <= dec_addr;
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        if (dec_addr == CTRL_OFS) begin
            read_mux[1:0] = ctrl_r;
        end else if (dec_addr == STATUS_OFS) begin
            read_mux[STATUS_FLAG_BIT] = flag_r;
            read_mux[STATUS_STATE_LSB +: 2] = state_r;
            read_mux[STATUS_GRANT_BIT] = grant_r;
            read_mux[STATUS_QUIET_BIT] = quiet;
        end else if (dec_addr == WAKE_CAUSE_OFS) begin
            read_mux[CAUSE_W-1:0] = cause_r;
        end else if (dec_addr == ENTRY_COUNT_OFS) begin
            read_mux = entry_count_r;
        end else if (dec_addr == IDLE_CYCLES_OFS) begin
            read_mux = idle_cycles_r;
        end else if (dec_addr == ID_OFS) begin
            read_mux = BLOCK_ID;
        end else begin
            read_mux = 32'h0000_0000;
        end
    end

    // read data is loaded at the address phase so it stands in the data phase
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            rdata_r <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE_I) begin
            rdata_r <= read_mux;
        end
    end

    // control register: entry enable and the debugger halt request bit
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_pend_r && wr_addr_r == CTRL_OFS) begin
            ctrl_r <= HWDATA_I[1:0];
        end
    end

    // the coprocessor command write carries the operation fields
    assign cmd.crm = HWDATA_I[CMD_CRM_LSB +: 4];
    assign cmd.crn = HWDATA_I[CMD_CRN_LSB +: 4];
    assign cmd.op2 = HWDATA_I[CMD_OP2_LSB +: 3];
    assign cmd.op1 = HWDATA_I[CMD_OP1_LSB +: 3];
    assign wfi_cmd = wr_pend_r && wr_addr_r == CP_CMD_OFS && ctrl_r[CTRL_WFI_ENABLE_BIT]
                     && cmd.crn == WFI_CRN && cmd.crm == WFI_CRM
                     && cmd.op2 == WFI_OP2 && cmd.op1 == WFI_OP1;

    // wake sources
    // halt bit is a level: left set, it ends every later wait at once

    // inputs are taken as synchronous; asynchronous lines are synchronised outside
    assign wake_now.normal_int = ~NORMAL_INTERRUPT_N_I;
    assign wake_now.fast_int = ~FAST_INTERRUPT_N_I;
    assign wake_now.ext_debug = EXT_DEBUG_REQUEST_I;
    assign wake_now.halt_bit = ctrl_r[CTRL_HALT_REQ_BIT];
    assign wake_any = |wake_now;

    // quiescence
    // quiet lags the inputs a cycle, so entry also wants them idle now

    assign act.wb_empty = WRITE_BUFFERS_EMPTY_I;
    assign act.mem_idle = MEM_IDLE_I;
    assign act.tcm_idle = TCM_IDLE_I;
    assign act.cop_idle = COPROC_IDLE_I;
    assign idle_now = act.wb_empty & act.mem_idle & act.tcm_idle & act.cop_idle;

    wfi_quiet_monitor u_quiet (
        .clk_i(CLOCK_I),
        .srst_i(SRST_I),
        .arm_i(state_r == ST_DRAIN),
        .act_i(act),
        .dbus_en_i(DATA_BUS_CLOCK_ENABLE_I),
        .ibus_en_i(INSTR_BUS_CLOCK_ENABLE_I),
        .quiet_o(quiet)
    );

    // state machine
    // standby has no timeout: only a wake source ends it

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (wfi_cmd) begin
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // a wake arriving during the drain cancels the wait outright
                if (wake_any) begin
                    state_nxt = ST_RUN;
                end else if (quiet && idle_now) begin
                    state_nxt = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (wake_any) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // flag rises on entry and falls one cycle after the wake is sampled
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            flag_r <= 1'b0;
        end else if (state_r == ST_DRAIN && state_nxt == ST_STANDBY) begin
            flag_r <= 1'b1;
        end else if (state_r == ST_WAKE) begin
            flag_r <= 1'b0;
        end
    end

    // grant is withheld from the drain until one cycle after the flag falls
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            grant_r <= 1'b1;
        end else if (state_nxt == ST_DRAIN || state_r == ST_DRAIN) begin
            grant_r <= 1'b0;
        end else begin
            grant_r <= state_r == ST_RUN && !flag_r;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            core_en_r <= 1'b1;
        end else begin
            core_en_r <= !(state_nxt == ST_STANDBY);
        end
    end

    // bookkeeping visible to software
    // counters are writable so software can restart a measurement

    assign cause_clr = wr_pend_r && wr_addr_r == WAKE_CAUSE_OFS;
    assign cause_clr_mask = cause_clr ? HWDATA_I[CAUSE_W-1:0] : '0;

    // write-one-to-clear; a cause recorded in the same cycle survives the clear
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            cause_r <= '0;
        end else if (state_r == ST_STANDBY && wake_any) begin
            cause_r <= (cause_r & ~cause_clr_mask) | wake_now;
        end else begin
            cause_r <= cause_r & ~cause_clr_mask;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            entry_count_r <= 32'h0000_0000;
        end else if (wr_pend_r && wr_addr_r == ENTRY_COUNT_OFS) begin
            entry_count_r <= HWDATA_I;
        end else if (state_r == ST_DRAIN && state_nxt == ST_STANDBY) begin
            entry_count_r <= entry_count_r + 32'h0000_0001;
        end
    end

    // counts only while the flag is high, so it measures gated time
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            idle_cycles_r <= 32'h0000_0000;
        end else if (wr_pend_r && wr_addr_r == IDLE_CYCLES_OFS) begin
            idle_cycles_r <= HWDATA_I;
        end else if (flag_r) begin
            idle_cycles_r <= idle_cycles_r + 32'h0000_0001;
        end
    end

    // outputs

    assign LOW_POWER_IDLE_FLAG_O = flag_r;
    assign ACCESS_GRANT_O = grant_r;
    assign CORE_CLOCK_ENABLE_O = core_en_r;
    // combinational so the debug path keeps its phase with the returned test clock
    assign DEBUG_CLOCK_ENABLE_O = core_en_r | JTAG_CLOCK_ENABLE_I;

endmodule
`default_nettype wire

// ### tb/wfi_clock_stop_monitor.sv
// concurrent checks on the wait-for-interrupt block ports
`timescale 1ns/1ns
`default_nettype none
module wfi_clock_stop_checker
    import wfi_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic NORMAL_INTERRUPT_N_I,
    input wire logic FAST_INTERRUPT_N_I,
    input wire logic EXT_DEBUG_REQUEST_I,
    input wire logic JTAG_CLOCK_ENABLE_I,
    input wire logic WRITE_BUFFERS_EMPTY_I,
    input wire logic MEM_IDLE_I,
    input wire logic TCM_IDLE_I,
    input wire logic COPROC_IDLE_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic LOW_POWER_IDLE_FLAG_O,
    input wire logic ACCESS_GRANT_O,
    input wire logic CORE_CLOCK_ENABLE_O,
    input wire logic DEBUG_CLOCK_ENABLE_O
);
    wire logic wake = !NORMAL_INTERRUPT_N_I || !FAST_INTERRUPT_N_I || EXT_DEBUG_REQUEST_I;
    wire logic idle_all = WRITE_BUFFERS_EMPTY_I && MEM_IDLE_I && TCM_IDLE_I && COPROC_IDLE_I;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    sequence s_wake_out;
        (CORE_CLOCK_ENABLE_O && LOW_POWER_IDLE_FLAG_O) ##1 (!LOW_POWER_IDLE_FLAG_O && !ACCESS_GRANT_O)
            ##1 ACCESS_GRANT_O;
    endsequence
    property p_cmd_start;
        $fell(ACCESS_GRANT_O) |-> $past(HWDATA_I) == 32'h0000_0470 && $past(HADDR_I[7:0], 2) == CP_CMD_OFS;
    endproperty
    property p_wake_out;
        LOW_POWER_IDLE_FLAG_O && !CORE_CLOCK_ENABLE_O && wake |=> s_wake_out;
    endproperty
    property p_enter_quiet;
        $rose(LOW_POWER_IDLE_FLAG_O) |-> $past(idle_all) && $past(idle_all, 2) && !CORE_CLOCK_ENABLE_O;
    endproperty
    property p_flag_idle;
        LOW_POWER_IDLE_FLAG_O |-> !ACCESS_GRANT_O;
    endproperty
    property p_grant_late;
        $rose(ACCESS_GRANT_O) |-> !$past(LOW_POWER_IDLE_FLAG_O);
    endproperty
    property p_dbg_clk;
        DEBUG_CLOCK_ENABLE_O == (CORE_CLOCK_ENABLE_O || JTAG_CLOCK_ENABLE_I);
    endproperty
    property p_core_stop;
        !CORE_CLOCK_ENABLE_O |-> LOW_POWER_IDLE_FLAG_O;
    endproperty
    property p_bus_okay;
        HREADYOUT_O && !HRESP_O;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("grant fell without wait command");
    a_wake_out: assert property (p_wake_out) else $error("wake exit timing wrong");
    a_enter_quiet: assert property (p_enter_quiet) else $error("flag rose while busy");
    a_flag_idle: assert property (p_flag_idle) else $error("grant high during flag");
    a_grant_late: assert property (p_grant_late) else $error("grant rose with flag high");
    a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock enable wrong");
    a_core_stop: assert property (p_core_stop) else $error("core clock off outside standby");
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
endmodule
bind wfi_clock_stop wfi_clock_stop_checker chk_u (.*);
`default_nettype wire

// ### tb/wfi_power_partner.sv
// system clock gate and power control model
`timescale 1ns/1ns
`default_nettype none
module wfi_power_partner #(
    parameter int BUS_DIV = 2
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic flag_i,
    input wire logic jtag_i,
    input wire logic [2:0] req_i,
    input wire logic busy_i,
    output logic normal_n_o,
    output logic fast_n_o,
    output logic ext_dbg_o,
    output logic idle_o,
    output logic dbus_en_o,
    output logic ibus_en_o,
    output logic stop_clk_o
);
    int div_r;
    // raw sources registered here, so they arrive synchronous
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            normal_n_o <= 1'b1;
            fast_n_o <= 1'b1;
            ext_dbg_o <= 1'b0;
        end else begin
            normal_n_o <= !req_i[0];
            fast_n_o <= !req_i[1];
            ext_dbg_o <= req_i[2];
        end
    end
    always_ff @(posedge clk_i) begin
        div_r <= (srst_i || div_r == BUS_DIV - 1) ? 0 : div_r + 1;
    end
    assign dbus_en_o = (div_r == 0);
    assign ibus_en_o = (div_r == BUS_DIV - 1);
    assign idle_o = !busy_i;
    // jtag enable unregistered; a pending wake reopens the gate at once
    assign stop_clk_o = flag_i && !jtag_i && normal_n_o && fast_n_o && !ext_dbg_o;
    // ram power never switched here, so cache and translation rams stay up
endmodule
`default_nettype wire

// ### tb/tb_wfi_clock_stop.sv
// self-checking bench for the wait-for-interrupt block
`timescale 1ns/1ns
`default_nettype none
module tb_wfi_clock_stop
    import wfi_pkg::*;
;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0, jtag = 0, busy = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, req = 0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, norm_n, fast_n, edbg, idle, den, ien, flag, grant, core, dbg, stop;
    int fails = 0, comparisons = 0, cycles = 0;
    wfi_clock_stop dut_u (.CLOCK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
        .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .NORMAL_INTERRUPT_N_I(norm_n), .FAST_INTERRUPT_N_I(fast_n),
        .EXT_DEBUG_REQUEST_I(edbg), .JTAG_CLOCK_ENABLE_I(jtag), .WRITE_BUFFERS_EMPTY_I(idle),
        .MEM_IDLE_I(idle), .TCM_IDLE_I(idle), .COPROC_IDLE_I(idle), .DATA_BUS_CLOCK_ENABLE_I(den),
        .INSTR_BUS_CLOCK_ENABLE_I(ien), .LOW_POWER_IDLE_FLAG_O(flag), .ACCESS_GRANT_O(grant),
        .CORE_CLOCK_ENABLE_O(core), .DEBUG_CLOCK_ENABLE_O(dbg));
    wfi_power_partner #(.BUS_DIV(2)) partner_u (.clk_i(clk), .srst_i(srst), .flag_i(flag), .jtag_i(jtag),
        .req_i(req), .busy_i(busy), .normal_n_o(norm_n), .fast_n_o(fast_n), .ext_dbg_o(edbg), .idle_o(idle),
        .dbus_en_o(den), .ibus_en_o(ien), .stop_clk_o(stop));
    always #2 clk = ~clk;
    task close_out;
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // called right after an edge; answer waited for, never assumed
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wait_flag(input logic v);
        int n;
        n = 0;
        while (flag !== v && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk(flag, v);
    endtask
    task s_regs;
        ahb(0, CTRL_OFS, 0);
        chk(rd, 32'h1);
        ahb(0, ID_OFS, 0);
        chk(rd, BLOCK_ID);
        ahb(1, 8'h1c, 32'hffff_ffff);
        ahb(0, 8'h1c, 0);
        chk(rd, 32'h0);
        ahb(1, IDLE_CYCLES_OFS, 32'h0000_1234);
        ahb(0, IDLE_CYCLES_OFS, 0);
        chk(rd, 32'h0000_1234);
        ahb(0, STATUS_OFS, 0);
        chk(rd & 32'hf, 32'h8);
    endtask
    task s_ignored;
        ahb(1, CP_CMD_OFS, 32'h0000_0471);
        repeat (6) @(posedge clk);
        chk({flag, grant}, 2'b01);
        ahb(1, CTRL_OFS, 32'h0);
        ahb(1, CP_CMD_OFS, 32'h0000_0470);
        repeat (6) @(posedge clk);
        chk({flag, grant}, 2'b01);
        ahb(1, CTRL_OFS, 32'h1);
    endtask
    task s_drain;
        busy <= 1'b1;
        ahb(1, CP_CMD_OFS, 32'h0000_0470);
        repeat (12) @(posedge clk);
        chk({flag, grant, core}, 3'b001);
        req <= 3'h1;
        repeat (6) @(posedge clk);
        chk({flag, grant}, 2'b01);
        req <= 3'h0;
        busy <= 1'b0;
        ahb(1, WAKE_CAUSE_OFS, 32'hf);
    endtask
    task s_wake(input int i);
        ahb(1, CP_CMD_OFS, 32'h0000_0470);
        wait_flag(1'b1);
        repeat (20) @(posedge clk);
        chk({flag, core, stop}, 3'b101);
        ahb(0, STATUS_OFS, 0);
        chk(rd & 32'hf, 32'h5);
        jtag <= 1'b1;
        @(posedge clk);
        chk({dbg, stop}, 2'b10);
        jtag <= 1'b0;
        if (i < 3) begin
            // partner registers the request, so the design sees it at the second edge
            req <= 3'h1 << i;
            repeat (2) @(negedge clk);
            chk(core, 1'b0);
            @(negedge clk);
            chk({flag, core}, 2'b11);
            @(negedge clk);
            chk({flag, grant}, 2'b00);
            @(negedge clk);
            chk(grant, 1'b1);
            @(posedge clk);
            req <= 3'h0;
        end else begin
            ahb(1, CTRL_OFS, 32'h3);
            wait_flag(1'b0);
            chk(flag, 1'b0);
            ahb(1, CTRL_OFS, 32'h1);
        end
        ahb(0, WAKE_CAUSE_OFS, 0);
        chk(rd, 32'h1 << i);
        ahb(1, WAKE_CAUSE_OFS, 32'h1 << i);
        ahb(0, WAKE_CAUSE_OFS, 0);
        chk(rd, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        s_regs;
        s_ignored;
        s_drain;
        for (int i = 0; i < 4; i++)
            s_wake(i);
        ahb(0, ENTRY_COUNT_OFS, 0);
        chk(rd, 32'h4);
        close_out;
    end
endmodule
`default_nettype wire
